// *** src/mst_modem_status.sv ***
// modem status tracking with axi4-lite register access
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module mst_modem_status (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write address
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [mst_pkg::ADDR_W-1:0]    s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [mst_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [mst_pkg::DATA_W/8-1:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // axi4-lite read address
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [mst_pkg::ADDR_W-1:0]    s_axi_araddr,
  // axi4-lite read data
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [mst_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  // modem input pins, active low
  input  wire mst_pkg::mst_modem_in_t        modem_in,
  // modem output pins, active low
  output logic                               rts_n,
  output logic                               dtr_n,
  output logic                               aux_output_one_n,
  output logic                               aux_output_two_n,
  // transmitter and receiver core handshake
  input  wire logic                          tx_busy,
  input  wire logic                          tx_char_done,
  input  wire logic                          rx_above_trigger,
  output logic                               tx_halt,
  // interrupts
  output logic                               modem_irq,
  output logic                               irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [3:0] pin_stable;

  // all four modem inputs through the filtered synchroniser
  mst_pin_sync #(
    .WIDTH (4),
    .IDLE  (mst_pkg::RST_PIN_IDLE)
  ) u_pin_sync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin_in     (modem_in),
    .pin_stable (pin_stable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  mst_pkg::mst_modem_control_t modem_control_reg_r;
  logic [3:0]                  delta_r;
  logic [3:0]                  prev_level_r;
  logic [3:0]                  irq_status_r;
  logic [3:0]                  irq_mask_r;
  logic                        tx_halt_r;
  logic                        modem_irq_r;
  logic                        irq_r;
  logic                        rts_n_r;
  logic                        dtr_n_r;
  logic                        aux_one_n_r;
  logic                        aux_two_n_r;

  // bus state
  logic                        awready_r;
  logic                        wready_r;
  logic                        aw_got_r;
  logic                        w_got_r;
  logic [mst_pkg::ADDR_W-1:0]  waddr_r;
  logic [7:0]                  wbyte_r;
  logic                        wlane_r;
  logic                        bvalid_r;
  logic [1:0]                  bresp_r;
  logic                        arready_r;
  logic                        rvalid_r;
  logic [mst_pkg::DATA_W-1:0]  rdata_r;
  logic [1:0]                  rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // status levels: pins inverted or loopback from control bits

  logic       loop;
  logic [3:0] pin_level;
  logic [3:0] loop_level;
  logic [3:0] cur_level;

  assign loop       = modem_control_reg_r.loopback;
  assign pin_level  = ~pin_stable;
  assign loop_level = {modem_control_reg_r.aux_output_two,
                       modem_control_reg_r.aux_output_one,
                       modem_control_reg_r.dtr,
                       modem_control_reg_r.rts};
  assign cur_level  = loop ? loop_level : pin_level;

  ////////////////////////////////////////////////////////////////////////////
  // change detection; index 3 dcd, 2 ri, 1 dsr, 0 cts

  logic [3:0] change;
  logic [3:0] delta_set;

  assign change    = cur_level ^ prev_level_r;
  assign delta_set = {change[3],
                      prev_level_r[2] & ~cur_level[2],
                      change[1],
                      change[0]};

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  logic do_write;
  logic wr_control;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_mapped;
  logic rd_status;
  logic rd_mapped;

  assign aw_hs         = s_axi_awvalid & awready_r;
  assign w_hs          = s_axi_wvalid & wready_r;
  assign b_hs          = bvalid_r & s_axi_bready;
  assign ar_hs         = s_axi_arvalid & arready_r;
  assign r_hs          = rvalid_r & s_axi_rready;
  assign do_write      = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_control    = do_write & wlane_r & (waddr_r == mst_pkg::OFF_MODEM_CONTROL);
  assign wr_irq_status = do_write & wlane_r & (waddr_r == mst_pkg::OFF_IRQ_STATUS);
  assign wr_irq_mask   = do_write & wlane_r & (waddr_r == mst_pkg::OFF_IRQ_MASK);
  assign wr_mapped     = (waddr_r == mst_pkg::OFF_MODEM_STATUS)
                       | (waddr_r == mst_pkg::OFF_MODEM_CONTROL)
                       | (waddr_r == mst_pkg::OFF_IRQ_STATUS)
                       | (waddr_r == mst_pkg::OFF_IRQ_MASK);
  assign rd_status     = ar_hs & (s_axi_araddr == mst_pkg::OFF_MODEM_STATUS);
  assign rd_mapped     = (s_axi_araddr == mst_pkg::OFF_MODEM_STATUS)
                       | (s_axi_araddr == mst_pkg::OFF_MODEM_CONTROL)
                       | (s_axi_araddr == mst_pkg::OFF_IRQ_STATUS)
                       | (s_axi_araddr == mst_pkg::OFF_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // register next values

  logic [7:0]                  status_view;
  logic [3:0]                  delta_nxt;
  logic [3:0]                  irq_status_nxt;
  logic [3:0]                  irq_mask_nxt;
  mst_pkg::mst_modem_control_t control_nxt;
  logic [7:0]                  rd_byte;

  // read returns contents, then clears; a fresh change still lands
  assign status_view    = {cur_level, delta_r};
  assign delta_nxt      = (rd_status ? 4'h0 : delta_r) | delta_set;
  assign irq_status_nxt = (wr_irq_status ? (irq_status_r & ~wbyte_r[3:0])
                                         : irq_status_r) | delta_set;
  assign irq_mask_nxt   = wr_irq_mask ? wbyte_r[3:0] : irq_mask_r;
  assign control_nxt    = wr_control ? {2'h0, wbyte_r[5:0]} : modem_control_reg_r;
  assign rd_byte        = (s_axi_araddr == mst_pkg::OFF_MODEM_STATUS)  ? status_view :
                          (s_axi_araddr == mst_pkg::OFF_MODEM_CONTROL) ? modem_control_reg_r :
                          (s_axi_araddr == mst_pkg::OFF_IRQ_STATUS)    ? {4'h0, irq_status_r} :
                          (s_axi_araddr == mst_pkg::OFF_IRQ_MASK)      ? {4'h0, irq_mask_r} :
                          8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // flow control and modem outputs

  logic auto_cts;
  logic auto_rts;
  logic halt_want;
  logic halt_nxt;

  assign auto_cts  = modem_control_reg_r.auto_flow_enable;
  assign auto_rts  = modem_control_reg_r.auto_flow_enable
                   & modem_control_reg_r.rts;
  assign halt_want = auto_cts & ~cur_level[0];
  // halt only changes between characters
  assign halt_nxt  = (~tx_busy | tx_char_done) ? halt_want : tx_halt_r;

  ////////////////////////////////////////////////////////////////////////////
  // status, control and interrupt registers

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      modem_control_reg_r <= mst_pkg::RST_MODEM_CONTROL;
      delta_r             <= mst_pkg::RST_DELTA;
      prev_level_r        <= mst_pkg::RST_DELTA;
      irq_status_r        <= mst_pkg::RST_IRQ_STATUS;
      irq_mask_r          <= mst_pkg::RST_IRQ_MASK;
      modem_irq_r         <= 1'b0;
      irq_r               <= 1'b0;
      tx_halt_r           <= 1'b0;
    end
    else
    begin
      modem_control_reg_r <= control_nxt;
      delta_r             <= delta_nxt;
      prev_level_r        <= cur_level;
      irq_status_r        <= irq_status_nxt;
      irq_mask_r          <= irq_mask_nxt;
      modem_irq_r         <= |delta_nxt;
      irq_r               <= |(irq_status_nxt & irq_mask_nxt);
      tx_halt_r           <= halt_nxt;
    end
  end

  // modem outputs, held inactive in loopback
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rts_n_r     <= 1'b1;
      dtr_n_r     <= 1'b1;
      aux_one_n_r <= 1'b1;
      aux_two_n_r <= 1'b1;
    end
    else
    begin
      rts_n_r     <= control_nxt.loopback | (auto_rts ? rx_above_trigger
                                                      : ~control_nxt.rts);
      dtr_n_r     <= control_nxt.loopback | ~control_nxt.dtr;
      aux_one_n_r <= control_nxt.loopback | ~control_nxt.aux_output_one;
      aux_two_n_r <= control_nxt.loopback | ~control_nxt.aux_output_two;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      waddr_r   <= '0;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= mst_pkg::RESP_OKAY;
    end
    else
    begin
      awready_r <= aw_hs ? 1'b0 : (b_hs ? 1'b1 : awready_r);
      wready_r  <= w_hs ? 1'b0 : (b_hs ? 1'b1 : wready_r);
      aw_got_r  <= aw_hs | (aw_got_r & ~do_write);
      w_got_r   <= w_hs | (w_got_r & ~do_write);
      waddr_r   <= aw_hs ? s_axi_awaddr : waddr_r;
      wbyte_r   <= w_hs ? s_axi_wdata[7:0] : wbyte_r;
      wlane_r   <= w_hs ? s_axi_wstrb[0] : wlane_r;
      bvalid_r  <= do_write | (bvalid_r & ~s_axi_bready);
      bresp_r   <= do_write ? (wr_mapped ? mst_pkg::RESP_OKAY : mst_pkg::RESP_SLVERR)
                            : bresp_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= mst_pkg::RESP_OKAY;
    end
    else
    begin
      arready_r <= ar_hs ? 1'b0 : (r_hs ? 1'b1 : arready_r);
      rvalid_r  <= ar_hs | (rvalid_r & ~s_axi_rready);
      rdata_r   <= ar_hs ? {24'h000000, rd_byte} : rdata_r;
      rresp_r   <= ar_hs ? (rd_mapped ? mst_pkg::RESP_OKAY : mst_pkg::RESP_SLVERR)
                         : rresp_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops

  assign s_axi_awready    = awready_r;
  assign s_axi_wready     = wready_r;
  assign s_axi_bvalid     = bvalid_r;
  assign s_axi_bresp      = bresp_r;
  assign s_axi_arready    = arready_r;
  assign s_axi_rvalid     = rvalid_r;
  assign s_axi_rdata      = rdata_r;
  assign s_axi_rresp      = rresp_r;
  assign rts_n            = rts_n_r;
  assign dtr_n            = dtr_n_r;
  assign aux_output_one_n = aux_one_n_r;
  assign aux_output_two_n = aux_two_n_r;
  assign tx_halt          = tx_halt_r;
  assign modem_irq        = modem_irq_r;
  assign irq              = irq_r;

endmodule
`default_nettype wire

// *** src/mst_pin_sync.sv ***
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module mst_pin_sync #(
  parameter int          WIDTH = 4,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // pins and filtered result
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_stable
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] late_r;
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] stable_nxt;

  // a bit moves only once second and third stages agree
  assign stable_nxt = (sync_r & late_r) | (stable_r & (sync_r | late_r));
  assign pin_stable = stable_r;

  // synchroniser chain, first stage read only by second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r   <= IDLE;
      sync_r   <= IDLE;
      late_r   <= IDLE;
      stable_r <= IDLE;
    end
    else
    begin
      meta_r   <= pin_in;
      sync_r   <= meta_r;
      late_r   <= sync_r;
      stable_r <= stable_nxt;
    end
  end

endmodule
`default_nettype wire

// *** src/mst_pkg.sv ***
// constants, field layouts and carrier types of the modem status tracking block
//
// Operation
// - bit 7 is inverted carrier pin, or aux two
// - bit 6 is inverted ring pin, or aux one
// - bit 5 is inverted dsr pin, or dtr
// - bit 4 is inverted cts pin, or rts
// - auto flow: cts high halts after character
// - bits 3,1,0 set on any input change
// - bit 2 set only on ring pin rising
// - status read returns contents, then clears deltas
// - any delta bit set raises modem interrupt
// - auto flow alone selects cts automation; auto flow and rts select rts automation
`default_nettype none
package mst_pkg;

  //////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_MODEM_STATUS  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_MODEM_CONTROL = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS    = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK      = 4'hC;

  // reset values
  localparam logic [7:0] RST_MODEM_CONTROL = 8'h00;
  localparam logic [3:0] RST_IRQ_STATUS    = 4'h0;
  localparam logic [3:0] RST_IRQ_MASK      = 4'h0;
  localparam logic [3:0] RST_DELTA         = 4'h0;
  localparam logic [3:0] RST_PIN_IDLE      = 4'hF;   // active-low pins idle high

  // status field positions
  localparam int POS_DCD   = 7;
  localparam int POS_RI    = 6;
  localparam int POS_DSR   = 5;
  localparam int POS_CTS   = 4;
  localparam int POS_D_DCD = 3;
  localparam int POS_D_RI  = 2;
  localparam int POS_D_DSR = 1;
  localparam int POS_D_CTS = 0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // modem control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] reserved;
    logic       auto_flow_enable;   // bit 5
    logic       loopback;           // bit 4
    logic       aux_output_two;     // bit 3
    logic       aux_output_one;     // bit 2
    logic       rts;                // bit 1
    logic       dtr;                // bit 0
  } mst_modem_control_t;

  // modem input lines, raw active-low order dcd, ri, dsr, cts
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } mst_modem_in_t;

endpackage
`default_nettype wire

// *** verif/mst_modem_partner.sv ***
// modem model that drives the four active-low control lines of the block
`timescale 1ns/100ps
`default_nettype none
module mst_modem_partner (
  // clock
  input  wire logic                   aclk,
  // levels asked for by the bench
  input  wire mst_pkg::mst_modem_in_t level,
  // pins toward the block
  output var  mst_pkg::mst_modem_in_t modem_in
);
  // pins move just after an edge and hold clean levels, no glitches
  initial modem_in = mst_pkg::RST_PIN_IDLE;
  always @(posedge aclk)
    modem_in <= level;
endmodule
`default_nettype wire

// *** verif/mst_modem_status_sva.sv ***
// assertion checker for the modem status tracking block
`timescale 1ns/100ps
`default_nettype none
module mst_modem_status_sva (
  // clock and reset
  input wire logic                         aclk,
  input wire logic                         aresetn,
  // register bus
  input wire logic                         s_axi_awvalid,
  input wire logic                         s_axi_awready,
  input wire logic                         s_axi_wvalid,
  input wire logic                         s_axi_wready,
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_bready,
  input wire logic [1:0]                   s_axi_bresp,
  input wire logic                         s_axi_arvalid,
  input wire logic                         s_axi_arready,
  input wire logic [mst_pkg::ADDR_W-1:0]   s_axi_araddr,
  input wire logic                         s_axi_rvalid,
  input wire logic                         s_axi_rready,
  input wire logic [mst_pkg::DATA_W-1:0]   s_axi_rdata,
  // modem side and transmitter handshake
  input wire mst_pkg::mst_modem_in_t       modem_in,
  input wire logic                         dtr_n,
  input wire logic                         tx_busy,
  input wire logic                         tx_char_done,
  input wire logic                         tx_halt,
  input wire logic                         modem_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  //////////////////////////////////////////////////////////////////////////
  // cycles since the modem pins last moved
  mst_pkg::mst_modem_in_t prev_r;
  logic [3:0]             calm_r;
  always_ff @(posedge aclk)
  begin
    prev_r <= modem_in;
    calm_r <= (!aresetn || modem_in != prev_r) ? 4'h0 : calm_r + {3'h0, calm_r != 4'hF};
  end

  //////////////////////////////////////////////////////////////////////////
  // steps of a status read and of a pin event
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_status_read;
    s_ar_taken ##0 (s_axi_araddr == mst_pkg::OFF_MODEM_STATUS);
  endsequence
  sequence s_pin_event;
    !dtr_n && ($changed({modem_in.dcd_n, modem_in.dsr_n, modem_in.cts_n})
      || $rose(modem_in.ri_n));
  endsequence

  //////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read data missing");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_bus_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rdata_clean: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
    && !s_axi_arready) else $error("read data upper bits or ready wrong");
  a_status_live: assert property (
    s_status_read ##0 (calm_r > 4'h7 && !dtr_n) |=> s_axi_rdata[7:4] == ~$past(modem_in))
    else $error("status level does not mirror pins");
  a_read_irq: assert property (
    s_status_read |=> (|s_axi_rdata[3:0]) == $past(modem_irq))
    else $error("change bits and modem interrupt disagree");
  a_pin_irq: assert property (
    s_pin_event |-> ##[2:8] (modem_irq || s_axi_arvalid))
    else $error("pin change raised no modem interrupt");
  a_halt_hold: assert property (
    tx_busy && !tx_char_done |=> $stable(tx_halt)) else $error("halt moved mid character");
endmodule
bind mst_modem_status mst_modem_status_sva u_mst_modem_status_sva (.*);
`default_nettype wire

// *** verif/mst_modem_status_test.sv ***
// self-checking bench for the modem status tracking block
`timescale 1ns/100ps
`default_nettype none
module mst_modem_status_test;
  logic                        aclk, aresetn, tx_busy, tx_char_done, rx_above_trigger;
  logic                        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic                        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                        s_axi_arready, s_axi_rvalid, rts_n, dtr_n, tx_halt;
  logic                        aux_output_one_n, aux_output_two_n, modem_irq, irq;
  logic [mst_pkg::ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]                 s_axi_wdata, s_axi_rdata;
  logic [3:0]                  s_axi_wstrb, pin_lvl;
  logic [1:0]                  s_axi_bresp, s_axi_rresp;
  mst_pkg::mst_modem_in_t      modem_in;
  int                          failures, checks_done, cycles;

  mst_modem_partner u_mst_modem_partner (.aclk, .level(pin_lvl), .modem_in);
  mst_modem_status u_mst_modem_status (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .modem_in, .rts_n, .dtr_n,
    .aux_output_one_n, .aux_output_two_n, .tx_busy, .tx_char_done, .rx_above_trigger,
    .tx_halt, .modem_irq, .irq);

  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      wrap_up();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
    end
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_read(a, mst_pkg::RESP_OKAY, d);
    chk(what, exp, d);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd_chk("control", 4'h4, 32'h0);
    rd_chk("status", 4'h0, 32'h0);
    rd_chk("mask", 4'hC, 32'h0);
    chk("outputs", 32'hF, {28'h0, rts_n, dtr_n, aux_output_one_n, aux_output_two_n});
    chk("irqs", 32'h0, {30'h0, modem_irq, irq});
  endtask
  task automatic t_pins();
    axi_write(4'h4, 32'h01, mst_pkg::RESP_OKAY);
    chk("dtr out", 32'hB, {28'h0, rts_n, dtr_n, aux_output_one_n, aux_output_two_n});
    for (int i = 0; i < 4; i++)
    begin
      pin_lvl[i] <= 1'b0;
      repeat (10) @(posedge aclk);
      rd_chk("asserted", 4'h0, (32'h10 << i) | (i == 2 ? 32'h0 : 32'h1 << i));
      rd_chk("reread", 4'h0, 32'h10 << i);
      chk("irq quiet", 32'h0, {31'h0, modem_irq});
      pin_lvl[i] <= 1'b1;
      repeat (10) @(posedge aclk);
      chk("irq raised", 32'h1, {31'h0, modem_irq});
      rd_chk("released", 4'h0, 32'h1 << i);
    end
  endtask
  task automatic t_irq();
    axi_write(4'h8, 32'hF, mst_pkg::RESP_OKAY);
    pin_lvl[0] <= 1'b0;
    repeat (10) @(posedge aclk);
    rd_chk("irq status", 4'h8, 32'h1);
    chk("masked", 32'h0, {31'h0, irq});
    axi_write(4'hC, 32'h1, mst_pkg::RESP_OKAY);
    chk("unmasked", 32'h1, {31'h0, irq});
    axi_write(4'h8, 32'h1, mst_pkg::RESP_OKAY);
    chk("cleared", 32'h0, {31'h0, irq});
    pin_lvl[0] <= 1'b1;
    axi_write(4'hC, 32'h0, mst_pkg::RESP_OKAY);
    rd_chk("status", 4'h0, 32'h1);
    // cts release lands on the read edge, so its change must survive the clear
    chk("set wins irq", 32'h1, {31'h0, modem_irq});
    rd_chk("set wins", 4'h0, 32'h1);
  endtask
  task automatic t_loop();
    logic [31:0] d;
    axi_write(4'h4, 32'h15, mst_pkg::RESP_OKAY);
    axi_read(4'h0, mst_pkg::RESP_OKAY, d);
    chk("loop a", 32'h60, d & 32'hF0);
    chk("loop pins", 32'hF, {28'h0, rts_n, dtr_n, aux_output_one_n, aux_output_two_n});
    axi_write(4'h4, 32'h1A, mst_pkg::RESP_OKAY);
    axi_read(4'h0, mst_pkg::RESP_OKAY, d);
    chk("loop b", 32'h90, d & 32'hF0);
    axi_write(4'h4, 32'h01, mst_pkg::RESP_OKAY);
    repeat (10) @(posedge aclk);
    axi_read(4'h0, mst_pkg::RESP_OKAY, d);
  endtask
  task automatic t_flow();
    logic [31:0] d;
    axi_write(4'h4, 32'h23, mst_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("halt cts high", 32'h1, {31'h0, tx_halt});
    tx_busy    <= 1'b1;
    pin_lvl[0] <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("halt mid char", 32'h1, {31'h0, tx_halt});
    tx_char_done <= 1'b1;
    @(posedge aclk);
    tx_char_done <= 1'b0;
    tx_busy      <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("halt released", 32'h0, {31'h0, tx_halt});
    rx_above_trigger <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("auto rts full", 32'h1, {31'h0, rts_n});
    rx_above_trigger <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("auto rts room", 32'h0, {31'h0, rts_n});
    axi_write(4'h4, 32'h21, mst_pkg::RESP_OKAY);
    pin_lvl[0] <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("cts only rts", 32'h1, {31'h0, rts_n});
    chk("cts only halt", 32'h1, {31'h0, tx_halt});
    axi_write(4'h4, 32'h03, mst_pkg::RESP_OKAY);
    rx_above_trigger <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("manual", 32'h0, {30'h0, tx_halt, rts_n});
    axi_read(4'h0, mst_pkg::RESP_OKAY, d);
  endtask
  task automatic t_bus();
    logic [31:0] d;
    axi_write(4'h0, 32'hFF, mst_pkg::RESP_OKAY);
    axi_write(4'h2, 32'hFF, mst_pkg::RESP_SLVERR);
    axi_read(4'h2, mst_pkg::RESP_SLVERR, d);
    // write with lane 0 disabled is answered but changes nothing
    s_axi_wstrb <= 4'h0;
    axi_write(4'h4, 32'hFF, mst_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd_chk("control kept", 4'h4, 32'h03);
    rd_chk("status kept", 4'h0, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {aresetn, tx_busy, tx_char_done, rx_above_trigger} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    pin_lvl     = mst_pkg::RST_PIN_IDLE;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_pins();
    t_irq();
    t_loop();
    t_flow();
    t_bus();
    wrap_up();
  end
endmodule
`default_nettype wire
